// ---- core/pllcc_pkg.sv ----
// Constants, register layout and carrier types for the PLL clock control block.
// ==========================================================================
// How it works
// - Interrupt enable is writable only in automatic mode, else reads zero; reset clears.
// - Lock change flag sets on each settled-status toggle; irq while flag and enable.
// - A read of pll_control clears the read-only lock change flag unless a settled toggle lands in the same cycle; reset clears.
// - In manual mode the lock change flag reads zero and no irq is raised.
// - Loop enable activates PLL and VCO clock; reset sets it.
// - Loop enable cannot be cleared while base clock select is one.
// - Base clock is half the selected source; 1 is VCO, 0 oscillator; reset clears.
// - Select cannot be set while loop enable is clear; two writes needed.
// - Switchover waits three oscillator edges and, while the loop runs, three VCO edges; output held static.
// - Exponent codes 00, 01, 10 give multipliers 1, 2, 4; software avoids 3.
// - Exponent field ignores writes while loop enabled; reset clears it.
// - Self bandwidth select chooses automatic (1) or manual (0); reset clears.
// - Settled flag is read-only status in automatic mode, zero in manual.
// - Track bit is status in automatic mode, read/write control in manual; reset 0.
// - Manual track value is kept through automatic mode and restored afterwards.
// - Twelve-bit multiplier treats zero as one; reset loads 64.
// - Multiplier bits ignore writes while loop enabled.
// - Upper four bits of multiplier_high read as zero.
// - Eight-bit VCO range register ignores writes while loop enabled; reset 64.
// - VCO range zero disables PLL, clears select and blocks setting it.
package pllcc_pkg;

    // ======================================================================
    // Register byte addresses
    localparam logic [7:0] OFS_PLL_CONTROL       = 8'h00;
    localparam logic [7:0] OFS_BANDWIDTH_CONTROL = 8'h04;
    localparam logic [7:0] OFS_MULTIPLIER_HIGH   = 8'h08;
    localparam logic [7:0] OFS_MULTIPLIER_LOW    = 8'h0C;
    localparam logic [7:0] OFS_VCO_RANGE         = 8'h10;

    // ======================================================================
    // Field positions
    localparam int BIT_LOCK_IRQ_EN   = 7;
    localparam int BIT_LOCK_CHANGE   = 6;
    localparam int BIT_LOOP_ENABLE   = 5;
    localparam int BIT_BASE_SELECT   = 4;
    localparam int BIT_EXP_MSB       = 1;
    localparam int BIT_EXP_LSB       = 0;
    localparam int BIT_SELF_BW       = 7;
    localparam int BIT_SETTLED       = 6;
    localparam int BIT_TRACK         = 5;

    // ======================================================================
    // Reset values
    localparam logic        RST_LOOP_ENABLE = 1'b1;
    localparam logic [1:0]  RST_EXPONENT    = 2'h0;
    localparam logic [11:0] RST_MULTIPLIER  = 12'h040;
    localparam logic [7:0]  RST_RANGE_LIN   = 8'h40;

    // ======================================================================
    // Switchover and bus answers
    localparam logic [1:0]  SWITCH_EDGES    = 2'h3;
    localparam logic [11:0] MULT_ZERO       = 12'h000;
    localparam logic [11:0] MULT_ONE        = 12'h001;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Settings handed to the analog loop
    typedef struct packed {
        logic        loop_on;
        logic [1:0]  range_exponent;
        logic [7:0]  range_linear;
        logic [11:0] multiplier;
        logic        track_not_capture;
    } pllcc_cfg_t;

    // Status coming back from the analog loop
    typedef struct packed {
        logic settled;
        logic tracking;
    } pllcc_stat_t;

endpackage : pllcc_pkg

// ---- core/pllcc_top.sv ----
// PLL clock control registers, write protections and glitch-free base clock.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module pllcc_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Source clocks, sampled as pins
    input  wire logic                 oscillator_clock,
    input  wire logic                 vco_clock,
    // Analog loop status, asynchronous
    input  wire pllcc_pkg::pllcc_stat_t loop_status,
    // Outputs
    output pllcc_pkg::pllcc_cfg_t     loop_cfg,
    output logic                      base_clock_out,
    output logic                      lock_irq
);

    // ======================================================================
    // Pin synchronisers
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [1:0] clk_prev_q;
    logic       settled_prev_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {oscillator_clock, vco_clock,
                        loop_status.settled, loop_status.tracking};
            sync2_q <= sync1_q;
        end
    end

    wire osc_s      = sync2_q[3];
    wire vco_s      = sync2_q[2];
    wire settled_s  = sync2_q[1];
    wire tracking_s = sync2_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_prev_q     <= 2'h0;
            settled_prev_q <= 1'b0;
        end else begin
            clk_prev_q     <= {osc_s, vco_s};
            settled_prev_q <= settled_s;
        end
    end

    wire osc_edge       = osc_s & ~clk_prev_q[1];
    wire vco_edge       = vco_s & ~clk_prev_q[0];
    wire settled_toggle = settled_s ^ settled_prev_q;

    // ======================================================================
    // Register state
    logic        irq_en_q;
    logic        flag_q;
    logic        loop_en_q;
    logic        select_q;
    logic [1:0]  exponent_q;
    logic        self_bw_q;
    logic        track_manual_q;
    logic [11:0] mult_q;
    logic [7:0]  range_q;

    // ======================================================================
    // Write channel: address and data accepted in either order
    logic              aw_have_q;
    logic              w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0]        w_byte_q;
    logic              w_lane_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;

    assign s_axi_awready = ~aw_have_q;
    assign s_axi_wready  = ~w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    wire aw_fire  = s_axi_awvalid & s_axi_awready;
    wire w_fire   = s_axi_wvalid & s_axi_wready;
    wire wr_go    = aw_have_q & w_have_q & ~bvalid_q;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction : hit

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, pllcc_pkg::OFS_PLL_CONTROL) |
                 hit(a, pllcc_pkg::OFS_BANDWIDTH_CONTROL) |
                 hit(a, pllcc_pkg::OFS_MULTIPLIER_HIGH) |
                 hit(a, pllcc_pkg::OFS_MULTIPLIER_LOW) |
                 hit(a, pllcc_pkg::OFS_VCO_RANGE);
    endfunction : mapped

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= '0;
            w_byte_q  <= 8'h00;
            w_lane_q  <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (w_fire) begin
                w_have_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= pllcc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(aw_addr_q) ? pllcc_pkg::RESP_OKAY : pllcc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Byte lane 0 carries every register; other lanes are ignored
    wire wr_en     = wr_go & w_lane_q;
    wire wr_ctl    = wr_en & hit(aw_addr_q, pllcc_pkg::OFS_PLL_CONTROL);
    wire wr_bw     = wr_en & hit(aw_addr_q, pllcc_pkg::OFS_BANDWIDTH_CONTROL);
    wire wr_mh     = wr_en & hit(aw_addr_q, pllcc_pkg::OFS_MULTIPLIER_HIGH);
    wire wr_ml     = wr_en & hit(aw_addr_q, pllcc_pkg::OFS_MULTIPLIER_LOW);
    wire wr_rng    = wr_en & hit(aw_addr_q, pllcc_pkg::OFS_VCO_RANGE);

    // ======================================================================
    // Protected next values
    wire range_zero   = (range_q == 8'h00);
    wire wb_loop      = w_byte_q[pllcc_pkg::BIT_LOOP_ENABLE];
    wire wb_select    = w_byte_q[pllcc_pkg::BIT_BASE_SELECT];
    wire frozen       = loop_en_q;

    // Clearing refused while base clock select chooses the VCO
    wire loop_en_d    = wr_ctl ? (wb_loop | select_q) : loop_en_q;
    // Setting refused unless the loop was already on and the range is valid
    wire select_ok    = loop_en_q & ~range_zero;
    wire select_d     = range_zero ? 1'b0 :
                        wr_ctl     ? (wb_select & select_ok) : select_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_q   <= 1'b0;
            loop_en_q  <= pllcc_pkg::RST_LOOP_ENABLE;
            select_q   <= 1'b0;
            exponent_q <= pllcc_pkg::RST_EXPONENT;
        end else begin
            loop_en_q <= loop_en_d;
            select_q  <= select_d;
            if (!self_bw_q) begin
                irq_en_q <= 1'b0;
            end else if (wr_ctl) begin
                irq_en_q <= w_byte_q[pllcc_pkg::BIT_LOCK_IRQ_EN];
            end
            if (wr_ctl && !frozen) begin
                exponent_q <= w_byte_q[pllcc_pkg::BIT_EXP_MSB:pllcc_pkg::BIT_EXP_LSB];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            self_bw_q      <= 1'b0;
            track_manual_q <= 1'b0;
        end else if (wr_bw) begin
            self_bw_q <= w_byte_q[pllcc_pkg::BIT_SELF_BW];
            // Automatic mode leaves the stored manual choice untouched
            if (!self_bw_q) begin
                track_manual_q <= w_byte_q[pllcc_pkg::BIT_TRACK];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mult_q  <= pllcc_pkg::RST_MULTIPLIER;
            range_q <= pllcc_pkg::RST_RANGE_LIN;
        end else if (!frozen) begin
            if (wr_mh) begin
                mult_q[11:8] <= w_byte_q[3:0];
            end
            if (wr_ml) begin
                mult_q[7:0] <= w_byte_q;
            end
            if (wr_rng) begin
                range_q <= w_byte_q;
            end
        end
    end

    // ======================================================================
    // Read channel
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    wire ar_fire = s_axi_arvalid & s_axi_arready;
    wire rd_ctl  = ar_fire & hit(s_axi_araddr, pllcc_pkg::OFS_PLL_CONTROL);

    wire settled_vis = self_bw_q & settled_s;
    wire flag_vis    = self_bw_q & flag_q;
    wire track_vis   = self_bw_q ? tracking_s : track_manual_q;

    logic [7:0] ctl_byte;
    logic [7:0] bw_byte;
    always_comb begin
        ctl_byte = 8'h00;
        ctl_byte[pllcc_pkg::BIT_LOCK_IRQ_EN] = irq_en_q;
        ctl_byte[pllcc_pkg::BIT_LOCK_CHANGE] = flag_vis;
        ctl_byte[pllcc_pkg::BIT_LOOP_ENABLE] = loop_en_q;
        ctl_byte[pllcc_pkg::BIT_BASE_SELECT] = select_q;
        ctl_byte[pllcc_pkg::BIT_EXP_MSB:pllcc_pkg::BIT_EXP_LSB] = exponent_q;
        bw_byte = 8'h00;
        bw_byte[pllcc_pkg::BIT_SELF_BW] = self_bw_q;
        bw_byte[pllcc_pkg::BIT_SETTLED] = settled_vis;
        bw_byte[pllcc_pkg::BIT_TRACK]   = track_vis;
    end

    wire [7:0] rd_byte =
        hit(s_axi_araddr, pllcc_pkg::OFS_PLL_CONTROL)       ? ctl_byte :
        hit(s_axi_araddr, pllcc_pkg::OFS_BANDWIDTH_CONTROL) ? bw_byte :
        hit(s_axi_araddr, pllcc_pkg::OFS_MULTIPLIER_HIGH)   ? {4'h0, mult_q[11:8]} :
        hit(s_axi_araddr, pllcc_pkg::OFS_MULTIPLIER_LOW)    ? mult_q[7:0] :
        hit(s_axi_araddr, pllcc_pkg::OFS_VCO_RANGE)         ? range_q : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= pllcc_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= mapped(s_axi_araddr) ? pllcc_pkg::RESP_OKAY : pllcc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ======================================================================
    // Lock change flag: a toggle in the clearing cycle keeps the flag set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q <= 1'b0;
        end else if (self_bw_q && settled_toggle) begin
            flag_q <= 1'b1;
        end else if (rd_ctl || !self_bw_q) begin
            flag_q <= 1'b0;
        end
    end

    assign lock_irq = flag_vis & irq_en_q;

    // ======================================================================
    // Base clock: halve the active source, freeze while switching over
    logic       cur_src_q;
    logic       base_q;
    logic [1:0] osc_cnt_q;
    logic [1:0] vco_cnt_q;

    wire loop_run   = loop_en_q & ~range_zero;
    wire switching  = (cur_src_q != select_q);
    wire osc_done   = (osc_cnt_q == pllcc_pkg::SWITCH_EDGES);
    // A stopped VCO cannot supply edges, so its count is waived when off
    wire vco_done   = (vco_cnt_q == pllcc_pkg::SWITCH_EDGES) | ~loop_run;
    wire src_edge   = cur_src_q ? (vco_edge & loop_run) : osc_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_src_q <= 1'b0;
            osc_cnt_q <= 2'h0;
            vco_cnt_q <= 2'h0;
        end else if (!switching) begin
            osc_cnt_q <= 2'h0;
            vco_cnt_q <= 2'h0;
        end else if (osc_done && vco_done) begin
            cur_src_q <= select_q;
        end else begin
            if (osc_edge && !osc_done) begin
                osc_cnt_q <= osc_cnt_q + 2'h1;
            end
            if (vco_edge && vco_cnt_q != pllcc_pkg::SWITCH_EDGES) begin
                vco_cnt_q <= vco_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_q <= 1'b0;
        end else if (!switching && src_edge) begin
            base_q <= ~base_q;
        end
    end

    assign base_clock_out = base_q;

    // ======================================================================
    // Settings to the analog loop, registered
    pllcc_pkg::pllcc_cfg_t cfg_q;
    wire [11:0] mult_eff = (mult_q == pllcc_pkg::MULT_ZERO) ? pllcc_pkg::MULT_ONE : mult_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= '0;
        end else begin
            cfg_q.loop_on           <= loop_run;
            cfg_q.range_exponent    <= exponent_q;
            cfg_q.range_linear      <= range_q;
            cfg_q.multiplier        <= mult_eff;
            cfg_q.track_not_capture <= track_vis;
        end
    end

    assign loop_cfg = cfg_q;

endmodule : pllcc_top

`default_nettype wire

// ---- tb/pllcc_assertions.sv ----
// Port-level assertions for the PLL clock control block.
`timescale 1ns/1ns
`default_nettype none

module pllcc_checker #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic                   aclk,
    input wire logic                   aresetn,
    // Register bus
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [ADDR_W-1:0]      s_axi_araddr,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    // Loop side
    input wire pllcc_pkg::pllcc_stat_t loop_status,
    input wire pllcc_pkg::pllcc_cfg_t  loop_cfg,
    input wire logic                   lock_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    wire rd_take = s_axi_arvalid && s_axi_arready;

    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    a_rd_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read data late");
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rd_unmapped: assert property (rd_take && (s_axi_araddr >> 2) > (pllcc_pkg::OFS_VCO_RANGE >> 2)
        |=> s_axi_rresp == pllcc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    a_mult_nonzero: assert property ($past(aresetn) |-> loop_cfg.multiplier != 12'h000)
        else $error("multiplier shows zero");
    a_range_zero: assert property (loop_cfg.range_linear == 8'h00 |-> !loop_cfg.loop_on)
        else $error("loop on with zero range");
    a_read_clear: assert property ($stable(loop_status.settled)[*5] ##0
        (rd_take && s_axi_araddr == pllcc_pkg::OFS_PLL_CONTROL) |=> !lock_irq)
        else $error("lock irq kept after control read");

    c_irq: cover property (lock_irq);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == pllcc_pkg::RESP_SLVERR);
    c_loop_off: cover property ($fell(loop_cfg.loop_on));
endmodule : pllcc_checker

bind pllcc_top pllcc_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the PLL clock control block.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] d;
        logic [1:0]  r;
    } pllcc_exp_t;

    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, oscillator_clock, vco_clock, base_clock_out, lock_irq, b_prev;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rb;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    pllcc_pkg::pllcc_stat_t loop_status;
    pllcc_pkg::pllcc_cfg_t  loop_cfg;
    pllcc_exp_t  exp_q[$];
    pllcc_exp_t  e;
    int          n_mismatch = 0, tests_run = 0, cyc = 0, n_tog = 0;

    pllcc_top #(.ADDR_W(8)) uut (.*);

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    // =====================================================================
    // Bus master
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic b_ok;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            b_ok = s_axi_bvalid;
        end while (b_ok !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, pllcc_pkg::RESP_OKAY}, {30'h0, s_axi_bresp});
    endtask : wr

    // Expected data queued here, compared by the read monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        logic r_ok;
        @(posedge aclk);
        exp_q.push_back('{a, {24'h0, d}, (a > 8'h10) ? pllcc_pkg::RESP_SLVERR : pllcc_pkg::RESP_OKAY});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            r_ok = s_axi_rvalid;
        end while (r_ok !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Window wide enough that one edge of slack covers phase
    task automatic tog(input int x);
        int t0;
        repeat (40) @(posedge aclk);
        t0 = n_tog;
        repeat (120) @(posedge aclk);
        chk("base_toggles", 32'h1, 32'((n_tog - t0 >= x - 1) && (n_tog - t0 <= x + 1)));
    endtask : tog

    always @(posedge aclk) begin
        if (aresetn === 1'b1 && s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("read_unexpected", 32'h0, 32'h1);
            end else begin
                e = exp_q.pop_front();
                chk($sformatf("rdata_%h", e.a), e.d, s_axi_rdata);
                chk($sformatf("rresp_%h", e.a), {30'h0, e.r}, {30'h0, s_axi_rresp});
            end
        end
    end

    // Source pins: oscillator period 8 cycles, VCO period 6 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        b_prev <= base_clock_out;
        if (aresetn && base_clock_out !== b_prev) n_tog <= n_tog + 1;
        if (cyc % 4 == 0) oscillator_clock <= ~oscillator_clock;
        if (cyc % 3 == 0) vco_clock <= ~vco_clock;
        if (cyc == 8000) begin
            n_mismatch++;
            summarize();
        end
    end

    // =====================================================================
    // Main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {oscillator_clock, vco_clock, b_prev} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wstrb = 4'h1;
        loop_status = '0;
        rb = 8'($urandom(32'hAB6B));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("loop_cfg", {8'h0, 1'b1, 2'h0, 8'h40, 12'h040, 1'b0}, {8'h0, loop_cfg});
        rd(8'h00, 8'h20);
        rd(8'h04, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h0C, 8'h40);
        rd(8'h10, 8'h40);
        rd(8'h14, 8'h00);
        wr(8'h0C, rb);
        wr(8'h08, 8'h05);
        wr(8'h10, 8'h11);
        wr(8'h00, 8'h22);
        rd(8'h0C, 8'h40);
        rd(8'h08, 8'h00);
        rd(8'h10, 8'h40);
        rd(8'h00, 8'h20);
        wr(8'h00, 8'h30);
        rd(8'h00, 8'h30);
        tog(20);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h20);
        tog(15);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h30);
        rd(8'h00, 8'h20);
        wr(8'h00, 8'h00);
        wr(8'h08, 8'hFF);
        rd(8'h08, 8'h0F);
        wr(8'h08, 8'h00);
        wr(8'h0C, 8'h00);
        // Settings reach loop_cfg one edge after the register changes
        @(posedge aclk);
        chk("multiplier", 32'h1, {20'h0, loop_cfg.multiplier});
        rb = 8'($urandom());
        wr(8'h0C, rb);
        rd(8'h0C, rb);
        for (int k = 0; k < 3; k++) begin
            wr(8'h00, 8'(k));
            @(posedge aclk);
            chk("range_exponent", 32'(k), {30'h0, loop_cfg.range_exponent});
        end
        wr(8'h10, 8'h00);
        wr(8'h00, 8'h20);
        wr(8'h00, 8'h30);
        rd(8'h00, 8'h20);
        chk("loop_on", 32'h0, {31'h0, loop_cfg.loop_on});
        wr(8'h00, 8'h00);
        wr(8'h10, 8'h40);
        wr(8'h00, 8'h80);
        rd(8'h00, 8'h00);
        wr(8'h04, 8'h20);
        rd(8'h04, 8'h20);
        loop_status.settled <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(8'h04, 8'h20);
        rd(8'h00, 8'h00);
        chk("lock_irq", 32'h0, {31'h0, lock_irq});
        // Track bit still manual in this write, so keep it set for the restore check
        wr(8'h04, 8'hA0);
        rd(8'h04, 8'hC0);
        wr(8'h00, 8'h80);
        rd(8'h00, 8'h80);
        loop_status.settled <= 1'b0;
        repeat (8) @(posedge aclk);
        chk("lock_irq", 32'h1, {31'h0, lock_irq});
        rd(8'h00, 8'hC0);
        rd(8'h00, 8'h80);
        chk("lock_irq", 32'h0, {31'h0, lock_irq});
        wr(8'h04, 8'h00);
        rd(8'h04, 8'h20);
        rd(8'h00, 8'h00);
        repeat (5) @(posedge aclk);
        chk("pending_reads", 32'h0, 32'(exp_q.size()));
        summarize();
    end
endmodule : tb_top

`default_nettype wire
